/* File: logic/cmp_pkg.sv */
`default_nettype none
package cmp_pkg;
    localparam int NUM_OBJ = 6;
    localparam int DATA_DEPTH = 8;
    // Register indices; the byte address is four times the index.
    localparam logic [11:0] IDX_EN = 12'h0DC;
    localparam logic [11:0] IDX_PEND = 12'h0E0;
    localparam logic [11:0] IDX_TXERR = 12'h0EA;
    localparam logic [11:0] IDX_RXERR = 12'h0EB;
    localparam logic [11:0] IDX_TOP = 12'h0EC;
    localparam logic [11:0] IDX_PAGE = 12'h0ED;
    localparam logic [11:0] IDX_STMOB = 12'h0EE;
    localparam logic [11:0] IDX_CDMOB = 12'h0EF;
    localparam logic [11:0] IDX_TAG = 12'h0F0;
    localparam logic [11:0] IDX_MSG = 12'h0FA;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [3:0] NO_OBJECT = 4'hF;
    // Object status bit positions.
    localparam int ST_LENWARN = 7;
    localparam int ST_TXDONE = 6;
    localparam int ST_RXDONE = 5;
    localparam int ST_BITERR = 4;
    localparam int ST_STUFFERR = 3;
    localparam int ST_CRCERR = 2;
    localparam int ST_FORMERR = 1;
    localparam int ST_ACKERR = 0;
    // Configuration/length field positions and codes.
    localparam int CD_REPLY = 5;
    localparam int CD_IDE = 4;
    localparam logic [1:0] CFG_OFF = 2'h0;
    localparam logic [1:0] CFG_TX = 2'h1;
    localparam logic [1:0] CFG_RX = 2'h2;
    localparam logic [1:0] CFG_FBUF = 2'h3;
    localparam logic [3:0] DLC_MAX = 4'h8;
    localparam int TAG_RTR = 2;
    // Frame timing in bit counts, CRC polynomial and error counter step and limit.
    localparam logic [2:0] EOF_TX_LAST = 3'h6;
    localparam logic [2:0] EOF_RX_LAST = 3'h5;
    localparam logic [2:0] STUFF_LIMIT = 3'h6;
    localparam logic [14:0] CRC_POLY = 15'h4599;
    localparam logic [7:0] TXERR_STEP = 8'h08;
    localparam logic [7:0] CNT_MAX = 8'hFF;

    typedef enum logic [3:0] {
        FLD_IDLE = 4'h0, FLD_SOF = 4'h1, FLD_ARB = 4'h2, FLD_CTRL = 4'h3,
        FLD_DATA = 4'h4, FLD_CRC = 4'h5, FLD_CRC_DELIM = 4'h6, FLD_ACK_SLOT = 4'h7,
        FLD_ACK_DELIM = 4'h8, FLD_EOF = 4'h9, FLD_ERROR = 4'hA
    } cmp_field_e;

    typedef struct packed {
        logic valid;
        logic rx_level;
        logic tx_level;
        logic transmitting;
        logic stuff_bit;
        cmp_field_e field;
    } cmp_bit_s;

    typedef struct packed {
        logic [3:0] dlc;
        logic ide;
        logic [31:0] tag;
    } cmp_rx_meta_s;

    typedef struct packed {
        logic valid;
        logic [2:0] obj;
        logic [2:0] idx;
        logic [7:0] data;
    } cmp_rx_byte_s;

    typedef struct packed {
        logic request;
        logic [2:0] obj;
        logic [3:0] len;
        logic ide;
        logic [31:0] tag;
    } cmp_tx_desc_s;
endpackage : cmp_pkg
`default_nettype wire

/* File: logic/cmp_page_ctrl.sv */
// What this block does
// - Keep a readable 8-bit transmit error count from 0 to 255.
// - Keep a readable 8-bit receive error count from 0 to 255.
// - Priority high nibble shows lowest pending object, or 0xF when none pends.
// - Priority low nibble is free storage for a page preset.
// - Page high nibble selects the object, valid numbers 0 to 5.
// - Index advances after each data access when the active-low bit is 0.
// - Three-bit page index selects the data byte of the selected object.
// - Reception overwrites the length code and warns when it differs.
// - Transmit completion at end of frame; lowest enabled sender served first.
// - Receive completion after sixth end bit; only the lowest matching open object is updated.
// - Flag a sent/seen level mismatch, except arbitration loss and ack slot.
// - Flag a stuff error after more than five equal bits.
// - Check received CRC over start of frame through data field.
// - Flag a form error on bad delimiters or end-of-frame bits.
// - Flag an ack error when a sent frame sees no dominant ack.
// - Configuration code: 00 off, 01 transmit, 10 receive, 11 frame buffer.
// - Configuration stays after completion; rewriting with a code other than off clears completion and enables.
// - Reply-valid bit marks an automatic reply to a remote frame as ready.
// - Extension bit picks 11 or 29 bit identifiers; reception updates it.
// - Length code above 8 counts as 8; reception updates it.
// - Six pending bits, one per object, feed the priority report.
`timescale 1ns/100ps
`default_nettype none
module cmp_page_ctrl #(
    parameter int NUM_OBJ = cmp_pkg::NUM_OBJ
) (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Bit stream from the protocol engine.
    input wire cmp_pkg::cmp_bit_s bit_in,
    input wire cmp_pkg::cmp_rx_meta_s rx_meta,
    input wire logic [5:0] rx_hit,
    input wire cmp_pkg::cmp_rx_byte_s rx_byte,
    // Transmit side towards the protocol engine.
    input wire logic [2:0] tx_data_idx,
    output cmp_pkg::cmp_tx_desc_s tx_desc,
    output logic [7:0] tx_data_byte
);
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [3:0] lowest_set(input logic [5:0] v);
        logic [3:0] r;
        r = cmp_pkg::NO_OBJECT;
        for (int k = 5; k >= 0; k--) begin
            if (v[k]) begin
                r = 4'(k);
            end
        end
        return r;
    endfunction : lowest_set

    function automatic logic [14:0] crc_step(input logic [14:0] c, input logic b);
        return {c[13:0], 1'b0} ^ ((c[14] ^ b) ? cmp_pkg::CRC_POLY : 15'h0000);
    endfunction : crc_step

    function automatic logic [11:0] byte_addr(input logic [11:0] idx);
        return {idx[9:0], 2'b00};
    endfunction : byte_addr

    ////////////////////////////////////////////////////////////////////////////////
    logic [7:0] status_reg [NUM_OBJ];
    logic [7:0] status_next [NUM_OBJ];
    logic [7:0] cd_reg [NUM_OBJ];
    logic [7:0] cd_next [NUM_OBJ];
    logic [31:0] tag_reg [NUM_OBJ];
    logic [31:0] tag_next [NUM_OBJ];
    logic [7:0] data_mem [NUM_OBJ][cmp_pkg::DATA_DEPTH];
    logic [5:0] en_reg, en_next, reply_reg, reply_next;
    logic [7:0] txe_reg, txe_next, rxe_reg, rxe_next;
    logic [7:0] page_reg, page_next;
    logic [3:0] gp_reg, gp_next;
    logic [31:0] prdata_next;
    logic [2:0] cur_obj_reg, cur_obj_next;
    logic cur_valid_reg, cur_valid_next;
    logic [14:0] crc_reg, crc_next, crc_rx_reg, crc_rx_next;
    logic [2:0] run_reg, run_next, eof_reg, eof_next;
    logic last_reg, last_next;
    cmp_pkg::cmp_tx_desc_s tx_desc_next;

    // Bus decode.
    wire access = psel & penable;
    wire wr_en = access & pwrite;
    wire rd_access = access & ~pwrite;
    wire setup_rd = psel & ~penable & ~pwrite;
    wire hit_en = paddr == byte_addr(cmp_pkg::IDX_EN);
    wire hit_pend = paddr == byte_addr(cmp_pkg::IDX_PEND);
    wire hit_txe = paddr == byte_addr(cmp_pkg::IDX_TXERR);
    wire hit_rxe = paddr == byte_addr(cmp_pkg::IDX_RXERR);
    wire hit_hp = paddr == byte_addr(cmp_pkg::IDX_TOP);
    wire hit_page = paddr == byte_addr(cmp_pkg::IDX_PAGE);
    wire hit_st = paddr == byte_addr(cmp_pkg::IDX_STMOB);
    wire hit_cd = paddr == byte_addr(cmp_pkg::IDX_CDMOB);
    wire hit_tag = paddr == byte_addr(cmp_pkg::IDX_TAG);
    wire hit_msg = paddr == byte_addr(cmp_pkg::IDX_MSG);
    wire mapped = hit_en | hit_pend | hit_txe | hit_rxe | hit_hp | hit_page | hit_st
        | hit_cd | hit_tag | hit_msg;

    // Page fields; an object number above 5 selects nothing.
    wire [3:0] page_obj = page_reg[7:4];
    wire index_autoadvance_n = page_reg[3];
    wire [2:0] page_idx = page_reg[2:0];
    wire sel_ok = page_obj < 4'(NUM_OBJ);
    wire [2:0] sel = page_obj[2:0];
    wire data_acc = access & hit_msg & sel_ok;

    // Pending report.
    logic [5:0] irq_pend;
    logic [5:0] tx_cand;
    logic [5:0] rx_open;
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            irq_pend[i] = (i < NUM_OBJ) ? |status_reg[i % NUM_OBJ] : 1'b0;
            tx_cand[i] = (i < NUM_OBJ) ? en_reg[i] & ((cd_reg[i % NUM_OBJ][7:6] == cmp_pkg::CFG_TX)
                | reply_reg[i]) : 1'b0;
            rx_open[i] = (i < NUM_OBJ) ? en_reg[i] & cd_reg[i % NUM_OBJ][7] : 1'b0;
        end
    end
    wire [3:0] top_obj = lowest_set(irq_pend);
    wire [3:0] tx_pick = lowest_set(tx_cand);
    wire [3:0] rx_dflt = lowest_set(rx_open);
    wire [3:0] rx_tgt = lowest_set(rx_hit & rx_open);

    ////////////////////////////////////////////////////////////////////////////////
    // Frame checking on the bit stream.
    wire bv = bit_in.valid;
    wire rxl = bit_in.rx_level;
    wire txing = bit_in.transmitting;
    wire in_crc_fld = bit_in.field inside {cmp_pkg::FLD_SOF, cmp_pkg::FLD_ARB,
        cmp_pkg::FLD_CTRL, cmp_pkg::FLD_DATA};
    wire in_stuff_fld = in_crc_fld | (bit_in.field == cmp_pkg::FLD_CRC);
    wire is_sof = bv & (bit_in.field == cmp_pkg::FLD_SOF);
    wire is_eof = bit_in.field == cmp_pkg::FLD_EOF;
    wire arb_lost = (bit_in.field == cmp_pkg::FLD_ARB) & bit_in.tx_level & ~rxl;
    wire ack_dom = (bit_in.field == cmp_pkg::FLD_ACK_SLOT) & ~rxl;
    wire bit_err = bv & txing & (bit_in.tx_level != rxl) & ~arb_lost & ~ack_dom;
    wire stuff_err = bv & in_stuff_fld & (run_next == cmp_pkg::STUFF_LIMIT);
    wire crc_err = bv & ~txing & (bit_in.field == cmp_pkg::FLD_CRC_DELIM)
        & (crc_rx_reg != crc_reg);
    wire form_err = bv & ~rxl & (bit_in.field inside {cmp_pkg::FLD_CRC_DELIM,
        cmp_pkg::FLD_ACK_DELIM, cmp_pkg::FLD_EOF});
    wire ack_err = bv & txing & (bit_in.field == cmp_pkg::FLD_ACK_SLOT) & rxl;
    wire any_err = bit_err | stuff_err | crc_err | form_err | ack_err;
    wire tx_done = bv & is_eof & txing & (eof_reg == cmp_pkg::EOF_TX_LAST);
    wire rx_done = bv & is_eof & ~txing & (eof_reg == cmp_pkg::EOF_RX_LAST)
        & (rx_tgt != cmp_pkg::NO_OBJECT);
    wire [7:0] err_bits = {3'b000, bit_err, stuff_err, crc_err, form_err, ack_err};

    always_comb begin
        crc_next = crc_reg;
        crc_rx_next = crc_rx_reg;
        run_next = run_reg;
        last_next = last_reg;
        eof_next = eof_reg;
        if (bv) begin
            if (in_crc_fld & ~bit_in.stuff_bit) begin
                crc_next = crc_step(is_sof ? 15'h0000 : crc_reg, rxl);
            end
            if ((bit_in.field == cmp_pkg::FLD_CRC) & ~bit_in.stuff_bit) begin
                crc_rx_next = {crc_rx_reg[13:0], rxl};
            end
            if (in_stuff_fld) begin
                run_next = (rxl == last_reg && !is_sof && run_reg != 3'h7)
                    ? run_reg + 3'h1 : 3'h1;
                last_next = rxl;
            end else begin
                run_next = 3'h0;
            end
            eof_next = is_eof ? eof_reg + 3'h1 : 3'h0;
        end
    end

    // Errors land on the object picked at start of frame: the sender, or else the lowest open receiver.
    always_comb begin
        cur_obj_next = cur_obj_reg;
        cur_valid_next = cur_valid_reg;
        if (is_sof) begin
            cur_obj_next = txing ? tx_pick[2:0] : rx_dflt[2:0];
            cur_valid_next = txing ? (tx_pick != cmp_pkg::NO_OBJECT)
                : (rx_dflt != cmp_pkg::NO_OBJECT);
        end
    end

    // Error counters saturate at both ends.
    always_comb begin
        txe_next = txe_reg;
        rxe_next = rxe_reg;
        if (any_err & txing) begin
            txe_next = (txe_reg > cmp_pkg::CNT_MAX - cmp_pkg::TXERR_STEP)
                ? cmp_pkg::CNT_MAX : txe_reg + cmp_pkg::TXERR_STEP;
        end else if (tx_done & (txe_reg != 8'h00)) begin
            txe_next = txe_reg - 8'h01;
        end
        if (any_err & ~txing) begin
            rxe_next = (rxe_reg == cmp_pkg::CNT_MAX) ? rxe_reg : rxe_reg + 8'h01;
        end else if (rx_done & (rxe_reg != 8'h00)) begin
            rxe_next = rxe_reg - 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Per-object state; hardware status sets win over a software write in the same cycle.
    always_comb begin
        en_next = en_reg;
        reply_next = reply_reg;
        for (int i = 0; i < NUM_OBJ; i++) begin
            logic [7:0] set_v;
            logic sw_here;
            set_v = 8'h00;
            sw_here = wr_en & sel_ok & (sel == 3'(i));
            status_next[i] = status_reg[i];
            cd_next[i] = cd_reg[i];
            tag_next[i] = tag_reg[i];
            if (any_err & cur_valid_reg & (cur_obj_reg == 3'(i))) begin
                set_v = set_v | err_bits;
            end
            if (tx_done & cur_valid_reg & (cur_obj_reg == 3'(i))) begin
                set_v[cmp_pkg::ST_TXDONE] = 1'b1;
                en_next[i] = 1'b0;
                reply_next[i] = 1'b0;
                cd_next[i][cmp_pkg::CD_REPLY] = 1'b0;
            end
            if (rx_done & (rx_tgt == 4'(i))) begin
                set_v[cmp_pkg::ST_RXDONE] = 1'b1;
                set_v[cmp_pkg::ST_LENWARN] = rx_meta.dlc != cd_reg[i][3:0];
                cd_next[i][3:0] = rx_meta.dlc;
                cd_next[i][cmp_pkg::CD_IDE] = rx_meta.ide;
                tag_next[i] = rx_meta.tag;
                if (rx_meta.tag[cmp_pkg::TAG_RTR] & cd_reg[i][cmp_pkg::CD_REPLY]) begin
                    reply_next[i] = 1'b1;
                end else if (cd_reg[i][7:6] != cmp_pkg::CFG_FBUF) begin
                    en_next[i] = 1'b0;
                end
            end
            if (sw_here & hit_st) begin
                status_next[i] = pwdata[7:0];
            end
            if (sw_here & hit_cd) begin
                cd_next[i] = pwdata[7:0];
                en_next[i] = pwdata[7:6] != cmp_pkg::CFG_OFF;
                reply_next[i] = 1'b0;
                if (pwdata[7:6] != cmp_pkg::CFG_OFF) begin
                    status_next[i][cmp_pkg::ST_TXDONE] = 1'b0;
                    status_next[i][cmp_pkg::ST_RXDONE] = 1'b0;
                end
            end
            if (sw_here & hit_tag) begin
                tag_next[i] = pwdata;
            end
            status_next[i] = status_next[i] | set_v;
        end
    end

    // Page register, general-purpose nibble and index advance.
    always_comb begin
        page_next = page_reg;
        gp_next = gp_reg;
        if (wr_en & hit_page) begin
            page_next = pwdata[7:0];
        end else if (data_acc & ~index_autoadvance_n) begin
            page_next[2:0] = page_idx + 3'h1;
        end
        if (wr_en & hit_hp) begin
            gp_next = pwdata[3:0];
        end
    end

    // Read data is captured in the setup cycle and shown in the access cycle.
    always_comb begin
        prdata_next = 32'h0000_0000;
        if (hit_en) begin
            prdata_next = {26'h0, en_reg};
        end else if (hit_pend) begin
            prdata_next = {26'h0, irq_pend};
        end else if (hit_txe) begin
            prdata_next = {24'h0, txe_reg};
        end else if (hit_rxe) begin
            prdata_next = {24'h0, rxe_reg};
        end else if (hit_hp) begin
            prdata_next = {24'h0, top_obj, gp_reg};
        end else if (hit_page) begin
            prdata_next = {24'h0, page_reg};
        end else if (sel_ok & hit_st) begin
            prdata_next = {24'h0, status_reg[sel]};
        end else if (sel_ok & hit_cd) begin
            prdata_next = {24'h0, cd_reg[sel]};
        end else if (sel_ok & hit_tag) begin
            prdata_next = tag_reg[sel];
        end else if (sel_ok & hit_msg) begin
            prdata_next = {24'h0, data_mem[sel][page_idx]};
        end
    end

    // Transmit descriptor for the lowest ready sender.
    always_comb begin
        tx_desc_next.request = tx_pick != cmp_pkg::NO_OBJECT;
        tx_desc_next.obj = tx_pick[2:0];
        tx_desc_next.len = 4'h0;
        tx_desc_next.ide = 1'b0;
        tx_desc_next.tag = 32'h0000_0000;
        if (tx_pick != cmp_pkg::NO_OBJECT) begin
            tx_desc_next.len = (cd_reg[tx_pick[2:0]][3:0] > cmp_pkg::DLC_MAX)
                ? cmp_pkg::DLC_MAX : cd_reg[tx_pick[2:0]][3:0];
            tx_desc_next.ide = cd_reg[tx_pick[2:0]][cmp_pkg::CD_IDE];
            tx_desc_next.tag = tag_reg[tx_pick[2:0]];
            if (reply_reg[tx_pick[2:0]]) begin
                tx_desc_next.tag[cmp_pkg::TAG_RTR] = 1'b0;
            end
        end
    end

    assign pready = 1'b1;
    assign pslverr = access & ~mapped;

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NUM_OBJ; i++) begin
                status_reg[i] <= cmp_pkg::RESET_BYTE;
                cd_reg[i] <= cmp_pkg::RESET_BYTE;
                tag_reg[i] <= 32'h0000_0000;
            end
            en_reg <= 6'h00;
            reply_reg <= 6'h00;
            txe_reg <= cmp_pkg::RESET_BYTE;
            rxe_reg <= cmp_pkg::RESET_BYTE;
            page_reg <= cmp_pkg::RESET_BYTE;
            gp_reg <= 4'h0;
            prdata <= 32'h0000_0000;
            cur_obj_reg <= 3'h0;
            cur_valid_reg <= 1'b0;
            crc_reg <= 15'h0000;
            crc_rx_reg <= 15'h0000;
            run_reg <= 3'h0;
            eof_reg <= 3'h0;
            last_reg <= 1'b1;
            tx_desc <= '0;
            tx_data_byte <= 8'h00;
        end else begin
            status_reg <= status_next;
            cd_reg <= cd_next;
            tag_reg <= tag_next;
            en_reg <= en_next;
            reply_reg <= reply_next;
            txe_reg <= txe_next;
            rxe_reg <= rxe_next;
            page_reg <= page_next;
            gp_reg <= gp_next;
            prdata <= setup_rd ? prdata_next : prdata;
            cur_obj_reg <= cur_obj_next;
            cur_valid_reg <= cur_valid_next;
            crc_reg <= crc_next;
            crc_rx_reg <= crc_rx_next;
            run_reg <= run_next;
            eof_reg <= eof_next;
            last_reg <= last_next;
            tx_desc <= tx_desc_next;
            tx_data_byte <= data_mem[tx_desc_next.obj % NUM_OBJ][tx_data_idx];
        end
    end

    // Data buffer has no reset; it is written by software and by reception.
    always_ff @(posedge pclk) begin
        if (data_acc & pwrite) begin
            data_mem[sel][page_idx] <= pwdata[7:0];
        end
        if (rx_byte.valid && rx_byte.obj < 3'(NUM_OBJ)) begin
            data_mem[rx_byte.obj][rx_byte.idx] <= rx_byte.data;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    prio_none_a: assert property ((irq_pend == 6'h00) |-> (top_obj == 4'hF))
        else $error("priority report not 0xF with nothing pending");
    prio_low_a: assert property (irq_pend[0] |-> (top_obj == 4'h0))
        else $error("object 0 pending but not reported");
    idx_adv_a: assert property ((data_acc & ~index_autoadvance_n & ~hit_page)
        |=> (page_reg[2:0] == $past(page_reg[2:0]) + 3'h1))
        else $error("buffer index did not advance");
    idx_hold_a: assert property ((data_acc & index_autoadvance_n) |=> $stable(page_reg))
        else $error("buffer index moved while advance disabled");
    txerr_sat_a: assert property ((txe_reg == 8'hFF) & ~tx_done |=> (txe_reg == 8'hFF))
        else $error("transmit error count wrapped");
    rxerr_step_a: assert property ((any_err & ~txing & (rxe_reg < 8'hFF))
        |=> (rxe_reg == $past(rxe_reg) + 8'h01))
        else $error("receive error count did not step");
    tx_complete_set_a: assert property ((tx_done & cur_valid_reg)
        |=> status_reg[$past(cur_obj_reg)][6])
        else $error("transmit completion flag missing");
    rx_complete_set_a: assert property (rx_done |=> status_reg[$past(rx_tgt[2:0])][5])
        else $error("receive completion flag missing");
    len_cap_a: assert property (tx_desc.len <= 4'h8)
        else $error("transmit length above eight");
    ack_flag_a: assert property ((ack_err & cur_valid_reg)
        |=> status_reg[$past(cur_obj_reg)][0])
        else $error("ack error not flagged");
    stuff_run_a: assert property (stuff_err |-> (run_next == 3'h6))
        else $error("stuff error on short run");
    cfg_en_a: assert property ((wr_en & hit_cd & sel_ok & (pwdata[7:6] != 2'h0)
        & ~tx_done & ~rx_done) |=> en_reg[$past(sel)])
        else $error("enable not set by configuration write");

    tx_done_c: cover property (tx_done);
    rx_done_c: cover property (rx_done);
    err_seen_c: cover property (any_err ##1 (access & hit_st));
    autoinc_c: cover property (data_acc ##2 data_acc);
endmodule : cmp_page_ctrl
`default_nettype wire

/* File: testbench/cmp_engine_model.sv */
`timescale 1ns/100ps
`default_nettype none
module cmp_engine_model (
    // Clock and frame request.
    input wire logic pclk,
    input wire logic go,
    input wire logic no_ack,
    // Bit stream towards the controller.
    output cmp_pkg::cmp_bit_s bit_in,
    output logic busy
);
    initial begin
        bit_in = '0;
        busy = 1'b0;
    end
    // Each bus bit is a one-cycle pulse followed by one idle cycle.
    task automatic send(input cmp_pkg::cmp_field_e f, input logic lvl, input logic seen);
        bit_in <= '{1'b1, seen, lvl, 1'b1, 1'b0, f};
        @(posedge pclk);
        bit_in.valid <= 1'b0;
        @(posedge pclk);
    endtask : send
    // Alternating levels keep the frame free of stuff violations.
    always @(posedge pclk) begin
        if (go && !busy) begin
            busy <= 1'b1;
            send(cmp_pkg::FLD_SOF, 1'b0, 1'b0);
            for (int i = 0; i < 4; i++) send(cmp_pkg::FLD_ARB, !i[0], !i[0]);
            for (int i = 0; i < 2; i++) send(cmp_pkg::FLD_CTRL, !i[0], !i[0]);
            for (int i = 0; i < 2; i++) send(cmp_pkg::FLD_CRC, !i[0], !i[0]);
            send(cmp_pkg::FLD_CRC_DELIM, 1'b1, 1'b1);
            send(cmp_pkg::FLD_ACK_SLOT, 1'b1, no_ack);
            // A missing ack aborts the frame with an error flag, so it never completes.
            if (no_ack) begin
                for (int i = 0; i < 6; i++) send(cmp_pkg::FLD_ERROR, 1'b0, 1'b0);
            end else begin
                send(cmp_pkg::FLD_ACK_DELIM, 1'b1, 1'b1);
                for (int i = 0; i < 7; i++) send(cmp_pkg::FLD_EOF, 1'b1, 1'b1);
            end
            busy <= 1'b0;
        end
    end
endmodule : cmp_engine_model
`default_nettype wire

/* File: testbench/can_mob_page_status_control_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module can_mob_page_status_control_tb_top;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic go = 1'b0, nack = 1'b0, pready, pslverr, busy, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    cmp_pkg::cmp_bit_s bit_in;
    cmp_pkg::cmp_tx_desc_s desc;
    int errors = 0, compares = 0, n;
    logic [28:0] rows [5] = '{{1'b0, cmp_pkg::IDX_TXERR, 8'h00, 8'h00},
        {1'b0, cmp_pkg::IDX_RXERR, 8'h00, 8'h00}, {1'b0, cmp_pkg::IDX_TOP, 8'h00, 8'hF0},
        {1'b1, cmp_pkg::IDX_TOP, 8'h0A, 8'hFA}, {1'b1, cmp_pkg::IDX_PAGE, 8'h58, 8'h58}};
    always #20 pclk = ~pclk;
    cmp_page_ctrl i_cmp_page_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .bit_in(bit_in), .rx_meta('0), .rx_hit(6'h00),
        .rx_byte('0), .tx_data_idx(3'h0), .tx_desc(desc), .tx_data_byte());
    cmp_engine_model i_cmp_engine_model (.pclk(pclk), .go(go), .no_ack(nack),
        .bit_in(bit_in), .busy(busy));
    task automatic end_sim;
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_sim
    task automatic check(input string s, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", s, e, g);
        end
    endtask : check
    task automatic apb(input logic w, input logic [11:0] i, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {i[9:0], 2'b00};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin errors++; end_sim(); end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic rdchk(input string s, input logic [11:0] i, input logic [7:0] e);
        apb(1'b0, i, 32'h0);
        check(s, {24'h0, e}, rd);
    endtask : rdchk
    task automatic frame(input logic a);
        nack <= a;
        go <= 1'b1;
        @(posedge pclk);
        go <= 1'b0;
        n = 0;
        do begin @(posedge pclk); n++; end while (busy !== 1'b0 && n < 200);
        if (n >= 200) begin errors++; end_sim(); end
        repeat (2) @(posedge pclk);
    endtask : frame
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        foreach (rows[k]) begin
            if (rows[k][28]) apb(1'b1, rows[k][27:16], {24'h0, rows[k][15:8]});
            rdchk("row", rows[k][27:16], rows[k][7:0]);
        end
        rdchk("unmapped", 12'h0E1, 8'h00);
        check("slverr", 32'h1, {31'h0, err});
        apb(1'b1, cmp_pkg::IDX_PAGE, 32'h0);
        apb(1'b1, cmp_pkg::IDX_CDMOB, 32'h48);
        frame(1'b1);
        rdchk("status", cmp_pkg::IDX_STMOB, 8'h01);
        rdchk("tx errors", cmp_pkg::IDX_TXERR, 8'h08);
        rdchk("prio", cmp_pkg::IDX_TOP, 8'h0A);
        apb(1'b1, cmp_pkg::IDX_STMOB, 32'h0);
        frame(1'b0);
        rdchk("status", cmp_pkg::IDX_STMOB, 8'h40);
        rdchk("tx errors", cmp_pkg::IDX_TXERR, 8'h07);
        rdchk("config", cmp_pkg::IDX_CDMOB, 8'h48);
        for (int k = 1; k < 4; k++) apb(1'b1, cmp_pkg::IDX_MSG, {24'h0, k[3:0], k[3:0]});
        rdchk("page", cmp_pkg::IDX_PAGE, 8'h03);
        apb(1'b1, cmp_pkg::IDX_PAGE, 32'h09);
        rdchk("byte", cmp_pkg::IDX_MSG, 8'h22);
        rdchk("page", cmp_pkg::IDX_PAGE, 8'h09);
        apb(1'b1, cmp_pkg::IDX_PAGE, 32'h60);
        apb(1'b1, cmp_pkg::IDX_CDMOB, 32'h48);
        rdchk("config", cmp_pkg::IDX_CDMOB, 8'h00);
        apb(1'b1, cmp_pkg::IDX_PAGE, 32'h0);
        apb(1'b1, cmp_pkg::IDX_CDMOB, 32'h4F);
        @(posedge pclk);
        check("length", 32'h8, {28'h0, desc.len});
        check("request", 32'h1, {31'h0, desc.request});
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdchk("tx errors", cmp_pkg::IDX_TXERR, 8'h00);
        rdchk("page", cmp_pkg::IDX_PAGE, 8'h00);
        end_sim();
    end
endmodule : can_mob_page_status_control_tb_top
`default_nettype wire
